// ### irqs_top.sv
// Interrupt request sequencer: sampling, pending detect and acknowledge
`timescale 1ns/10ps
`default_nettype none
module irqs_top (
    input  wire logic                  clock,
    input  wire logic                  nrst,
    input  wire irqs_pkg::irqs_req_t   req_pins,
    output var  irqs_pkg::irqs_ack_t   ack
);
    // The processor cycle is two clock periods: phase 0 is the rising half,
    // phase 1 the falling half. This keeps one edge and one clock.
    irqs_pkg::irqs_req_t  req_sync;
    irqs_pkg::irqs_req_t  sampled;
    irqs_pkg::irqs_req_t  next_sampled;
    irqs_pkg::irqs_state_t state;
    irqs_pkg::irqs_state_t next_state;
    logic                 phase;
    logic                 next_phase;
    logic                 pending;
    logic                 next_pending;
    logic                 detected;
    logic [4:0]           live_req;
    logic                 any_maskable;
    irqs_pkg::irqs_ack_t  next_ack;
    logic [2:0]           pick;

    irqs_sync u_sync (
        .clock  (clock),
        .nrst   (nrst),
        .pins   (req_pins),
        .synced (req_sync)
    );

    assign live_req     = req_sync.external_request;
    assign any_maskable = |sampled.external_request;
    // Core check; suppression is read at the falling half itself
    assign detected = phase && pending &&
        (sampled.nonmaskable ||
         (any_maskable && !req_sync.maskable_suppress_input));

    // Priority from the live lines, so a line dropped meanwhile loses
    always_comb begin
        pick = irqs_pkg::VEC_NONE;
        for (int i = irqs_pkg::NUM_MASKABLE - 1; i >= 0; i--) begin
            if (live_req[i]) begin
                pick = 3'(i + 1);
            end
        end
        if (req_sync.nonmaskable) begin
            pick = irqs_pkg::VEC_NMI;
        end
    end

    always_comb begin
        next_phase   = ~phase;
        next_sampled = sampled;
        next_pending = pending;
        next_state   = state;
        next_ack     = ack;
        next_ack.ack_start = 1'b0;
        if (!phase) begin
            next_sampled = req_sync;
        end else begin
            next_pending = |{sampled.external_request,
                             sampled.nonmaskable};
        end
        case (state)
            irqs_pkg::IRQS_IDLE: begin
                if (detected) begin
                    next_state = irqs_pkg::IRQS_ACK;
                    next_ack.acknowledge_output = 1'b1;
                    next_ack.ack_start = 1'b1;
                    next_ack.vector = pick;
                end
            end
            irqs_pkg::IRQS_ACK: begin
                // Holds one full processor cycle, releases at its end
                if (phase) begin
                    next_state = irqs_pkg::IRQS_IDLE;
                    next_ack.acknowledge_output = 1'b0;
                    next_pending = 1'b0;
                end
            end
            default: begin
                next_state = irqs_pkg::IRQS_IDLE;
                next_ack.acknowledge_output = 1'b0;
            end
        endcase
        if (!nrst) begin
            next_phase   = 1'b0;
            next_sampled = irqs_pkg::irqs_req_t'(0);
            next_pending = 1'b0;
            next_state   = irqs_pkg::IRQS_IDLE;
            next_ack     = '0;
        end
    end

    always_ff @(posedge clock) begin
        phase   <= next_phase;
        sampled <= next_sampled;
        pending <= next_pending;
        state   <= next_state;
        ack     <= next_ack;
    end

    // Counts the clocks of one acknowledge. This lets its length be
    // checked with a small counter rather than a long repetition.
    logic [1:0]           ack_len;
    logic [1:0]           next_ack_len;

    always_comb begin
        next_ack_len = 2'h0;
        if (nrst && ack.acknowledge_output) begin
            next_ack_len = ack_len + 2'h1;
        end
    end

    always_ff @(posedge clock) begin
        ack_len <= next_ack_len;
    end

    // Requests dropped before their acknowledge are outside the sources'
    // duty; the vector then falls to whatever is still live.

    a_ack_after_detect: assert property (@(posedge clock) disable iff (!nrst)
        (state == irqs_pkg::IRQS_IDLE && detected)
        |=> ack.acknowledge_output && ack.ack_start)
        else $error("acknowledge did not start after detection");
    a_ack_two_cycles: assert property (@(posedge clock) disable iff (!nrst)
        $rose(ack.acknowledge_output) |-> ack.acknowledge_output [*2]
        ##1 !ack.acknowledge_output)
        else $error("acknowledge length wrong");
    a_nmi_vector: assert property (@(posedge clock) disable iff (!nrst)
        (state == irqs_pkg::IRQS_IDLE && detected && req_sync.nonmaskable)
        |=> ack.vector == irqs_pkg::VEC_NMI)
        else $error("non-maskable vector not delivered");
    a_suppress_hides: assert property (@(posedge clock) disable iff (!nrst)
        (req_sync.maskable_suppress_input && !sampled.nonmaskable)
        |-> !detected)
        else $error("maskable request detected while suppressed");
    a_sample_inputs: assert property (@(posedge clock) disable iff (!nrst)
        !phase |=> sampled == $past(req_sync))
        else $error("inputs not captured");
    a_pending_follows: assert property (@(posedge clock) disable iff (!nrst)
        (phase && |sampled.external_request && state != irqs_pkg::IRQS_ACK)
        |=> pending)
        else $error("pending not raised");
    a_vector_live: assert property (@(posedge clock) disable iff (!nrst)
        (state == irqs_pkg::IRQS_IDLE && detected && !req_sync.nonmaskable
         && live_req[0]) |=> ack.vector == 3'h1)
        else $error("vector not from live priority");
    a_start_pulse: assert property (@(posedge clock) disable iff (!nrst)
        ack.ack_start |=> !ack.ack_start)
        else $error("start not a single pulse");
    a_ack_len_bound: assert property (@(posedge clock) disable iff (!nrst)
        ack.acknowledge_output |-> ack_len <= irqs_pkg::ACK_CYCLES)
        else $error("acknowledge held too long");
    a_ack_len_end: assert property (@(posedge clock) disable iff (!nrst)
        $fell(ack.acknowledge_output)
        |-> ack_len == irqs_pkg::ACK_CYCLES + 2'h1)
        else $error("acknowledge ended early");
    a_ack_state_match: assert property (@(posedge clock) disable iff (!nrst)
        ack.acknowledge_output == (state == irqs_pkg::IRQS_ACK))
        else $error("acknowledge output and state disagree");
    a_phase_toggle: assert property (@(posedge clock) disable iff (!nrst)
        phase |=> !phase)
        else $error("processor cycle phase stuck");
    a_pending_quiet: assert property (@(posedge clock) disable iff (!nrst)
        (phase && !(|sampled.external_request) && !sampled.nonmaskable)
        |=> !pending)
        else $error("pending raised with nothing captured");
    a_nmi_no_suppress: assert property (@(posedge clock) disable iff (!nrst)
        (phase && pending && sampled.nonmaskable) |-> detected)
        else $error("non-maskable request not detected");
    a_maskable_seen: assert property (@(posedge clock) disable iff (!nrst)
        (phase && pending && any_maskable
         && !req_sync.maskable_suppress_input) |-> detected)
        else $error("unsuppressed maskable request missed");
    a_pending_drop: assert property (@(posedge clock) disable iff (!nrst)
        (state == irqs_pkg::IRQS_ACK && phase) |=> !pending)
        else $error("pending kept after acknowledge");
    a_vector_hold: assert property (@(posedge clock) disable iff (!nrst)
        !ack.ack_start |-> $stable(ack.vector))
        else $error("vector changed outside acknowledge start");
    a_vector_named: assert property (@(posedge clock) disable iff (!nrst)
        ack.ack_start |-> ack.vector != irqs_pkg::VEC_NONE)
        else $error("acknowledge without a live request");

    c_maskable_ack: cover property (@(posedge clock) disable iff (!nrst)
        ack.ack_start && ack.vector != irqs_pkg::VEC_NMI);
    c_nmi_ack: cover property (@(posedge clock) disable iff (!nrst)
        ack.ack_start && ack.vector == irqs_pkg::VEC_NMI);
    c_suppressed: cover property (@(posedge clock) disable iff (!nrst)
        phase && pending && req_sync.maskable_suppress_input);
    // Non-maskable request acknowledged one to four clocks after it rises
    c_late_nmi: cover property (@(posedge clock) disable iff (!nrst)
        $rose(req_sync.nonmaskable) ##[1:4]
        (ack.ack_start && ack.vector == irqs_pkg::VEC_NMI));
    c_back_to_back: cover property (@(posedge clock) disable iff (!nrst)
        $fell(ack.acknowledge_output) ##[1:8] ack.ack_start);
endmodule : irqs_top
`default_nettype wire

// ### irqs_pkg.sv
// Package for the interrupt request sequencer: types and constants
package irqs_pkg;
    localparam int          NUM_MASKABLE    = 5;
    localparam logic [2:0]  VEC_NONE        = 3'h0;
    localparam logic [2:0]  VEC_NMI         = 3'h7;
    localparam logic [4:0]  REQ_RESET       = 5'h00;
    localparam logic [1:0]  ACK_CYCLES      = 2'h1;

    typedef enum logic [1:0] {
        IRQS_IDLE    = 2'b00,
        IRQS_PENDING = 2'b01,
        IRQS_ACK     = 2'b10
    } irqs_state_t;

    // Pin inputs bundled together
    typedef struct packed {
        logic [NUM_MASKABLE-1:0] external_request;
        logic                    nonmaskable;
        logic                    maskable_suppress_input;
    } irqs_req_t;

    // Acknowledge result towards the core
    typedef struct packed {
        logic       acknowledge_output;
        logic       ack_start;
        logic [2:0] vector;
    } irqs_ack_t;
endpackage : irqs_pkg

// ### irqs_sync.sv
// Two flip-flop synchroniser for the request pins
`timescale 1ns/10ps
`default_nettype none
module irqs_sync (
    input  wire logic                      clock,
    input  wire logic                      nrst,
    input  wire irqs_pkg::irqs_req_t       pins,
    output var  irqs_pkg::irqs_req_t       synced
);
    irqs_pkg::irqs_req_t stage1;
    irqs_pkg::irqs_req_t next_stage1;
    irqs_pkg::irqs_req_t next_synced;

    always_comb begin
        next_stage1 = nrst ? pins : '0;
        next_synced = nrst ? stage1 : '0;
    end

    // First stage feeds only the second stage
    always_ff @(posedge clock) begin
        stage1 <= next_stage1;
        synced <= next_synced;
    end
endmodule : irqs_sync
`default_nettype wire

// ### irqs_src_model.sv
// Request source model: raises lines on command, drops them when served
`timescale 1ns/10ps
`default_nettype none
module irqs_src_model (
    input  wire logic                clock,
    input  wire logic                nrst,
    input  wire irqs_pkg::irqs_req_t want,
    input  wire irqs_pkg::irqs_ack_t ack,
    output var  irqs_pkg::irqs_req_t pins
);
    logic [7:0] done_bit;

    // One-hot of the vector being served; bit 0 (no vector) is unused
    assign done_bit = ack.ack_start ? (8'h01 << ack.vector) : 8'h00;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            pins <= '0;
        end else begin
            // Hold each request line until its own acknowledge, not any other; suppress just follows want
            pins.external_request <= (pins.external_request
                | want.external_request) & ~done_bit[5:1];
            pins.nonmaskable <= (pins.nonmaskable | want.nonmaskable)
                & ~done_bit[7];
            pins.maskable_suppress_input <= want.maskable_suppress_input;
        end
    end
endmodule : irqs_src_model
`default_nettype wire

// ### test_interrupt_request_sequencer.sv
// Testbench for the interrupt request sequencer
`timescale 1ns/10ps
`default_nettype none
module test_interrupt_request_sequencer;
    logic                clock;
    logic                nrst;
    irqs_pkg::irqs_req_t want;
    irqs_pkg::irqs_req_t pins;
    irqs_pkg::irqs_ack_t ack;
    int                  n_errors;
    int                  checks_done;

    irqs_top u_dut (.clock(clock), .nrst(nrst), .req_pins(pins), .ack(ack));
    irqs_src_model u_src (.clock(clock), .nrst(nrst), .want(want),
        .ack(ack), .pins(pins));

    always #2.5 clock = ~clock;

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic complete_run;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run

    // Any phase is fine: a late request is only taken a cycle later
    task automatic raise(input logic [4:0] lines, input logic nmi);
        want.external_request <= lines;
        want.nonmaskable      <= nmi;
        @(posedge clock);
        want.external_request <= 5'h00;
        want.nonmaskable      <= 1'b0;
        @(posedge clock);
    endtask : raise

    // Outputs are judged at the falling edge, where they have settled
    task automatic wait_ack(input logic [2:0] vec, input int lim);
        int n;
        n = 0;
        @(negedge clock);
        while (ack.ack_start !== 1'b1) begin
            n++;
            if (n > 30) begin
                check("ack timeout", 8'h01, 8'h00);
                complete_run();
            end
            @(negedge clock);
        end
        check("latency ok", {7'h00, n <= lim}, 8'h01);
        check("vector", {5'h00, ack.vector}, {5'h00, vec});
        check("ack first", {7'h00, ack.acknowledge_output}, 8'h01);
        @(negedge clock);
        check("ack second", {7'h00, ack.acknowledge_output}, 8'h01);
        check("start pulse", {7'h00, ack.ack_start}, 8'h00);
        @(negedge clock);
        check("ack end", {7'h00, ack.acknowledge_output}, 8'h00);
        @(posedge clock);
    endtask : wait_ack

    task automatic t_lines;
        for (int i = 0; i < irqs_pkg::NUM_MASKABLE; i++) begin
            raise(5'h01 << i, 1'b0);
            wait_ack(3'(i + 1), 10);
            repeat (4) @(posedge clock);
        end
        $display("test lines done");
    endtask : t_lines

    task automatic t_priority;
        raise(5'h14, 1'b0);
        wait_ack(3'h3, 10);
        wait_ack(3'h5, 12);
        raise(5'h02, 1'b1);
        wait_ack(irqs_pkg::VEC_NMI, 10);
        wait_ack(3'h2, 12);
        $display("test priority done");
    endtask : t_priority

    task automatic t_suppress;
        want.maskable_suppress_input <= 1'b1;
        raise(5'h01, 1'b0);
        repeat (20) begin
            @(negedge clock);
            check("no ack", {7'h00, ack.ack_start}, 8'h00);
        end
        @(posedge clock);
        // Lifting suppression must release the request that stayed pending
        want.maskable_suppress_input <= 1'b0;
        wait_ack(3'h1, 10);
        $display("test suppress done");
    endtask : t_suppress

    // Non-maskable request rising after a maskable one was sampled
    task automatic t_late_nmi;
        raise(5'h01, 1'b0);
        raise(5'h00, 1'b1);
        wait_ack(irqs_pkg::VEC_NMI, 10);
        wait_ack(3'h1, 12);
        $display("test late nmi done");
    endtask : t_late_nmi

    initial begin
        clock = 1'b0;
        nrst = 1'b0;
        want = '0;
        n_errors = 0;
        checks_done = 0;
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        t_lines();
        t_priority();
        t_suppress();
        t_late_nmi();
        complete_run();
    end
endmodule : test_interrupt_request_sequencer
`default_nettype wire
